// ==== hw/spife_pkg.sv ====
// Shared constants for both ends of the serial slave front end.
package spife_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int          FRAME_BITS = 40;
  localparam int          ADDR_BITS  = 8;
  localparam int          DATA_BITS  = 32;
  localparam logic [7:0]  WRITE_FLAG = 8'h80;
  localparam logic [5:0]  ADDR_DONE  = 6'h08;
  localparam logic [5:0]  FRAME_LAST = 6'h27;
  localparam logic [5:0]  FRAME_FULL = 6'h28;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [7:0]  ADDR_RESET = 8'h00;
  localparam logic [1:0]  PIN_IDLE   = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYS_PERIOD_NS   = 10;
  localparam int SYS_KHZ         = 100000;
  localparam int FILT_NS         = 20;
  localparam int FILT_CYC        = (FILT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int DEV_CLK_KHZ     = 12000;
  localparam int SCK_DIV_RATIO   = 4;
  localparam int SCK_MARGIN_PCT  = 10;
  localparam int SCK_MAX_INT_KHZ = 3500;
  localparam int SCK_QUART_KHZ   = DEV_CLK_KHZ / SCK_DIV_RATIO * (100 - SCK_MARGIN_PCT) / 100;
  localparam int SCK_LIMIT_KHZ   = (SCK_QUART_KHZ < SCK_MAX_INT_KHZ) ? SCK_QUART_KHZ : SCK_MAX_INT_KHZ;
  localparam int SCK_HALF_CYC    = (SYS_KHZ + 2 * SCK_LIMIT_KHZ - 1) / (2 * SCK_LIMIT_KHZ);
  localparam int CS_GAP_CYC      = 2 * SCK_HALF_CYC;

endpackage : spife_pkg

// ==== hw/spife_if.sv ====
// Four-wire serial link between the master end and the slave end.
`timescale 1ns/1ps
`default_nettype none

interface spife_if;
  logic sck;
  logic cs_n;
  logic sdi;
  logic sdo;

  modport dev (
    input  sck,
    input  cs_n,
    input  sdi,
    output sdo
  );

  modport host (
    output sck,
    output cs_n,
    output sdi,
    input  sdo
  );
endinterface : spife_if

`default_nettype wire

// ==== hw/spife_dev.sv ====
// Slave end: serial shifter on the link clock, register bank on the system clock.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Master keeps clock at most quarter system clock.
// - Oscillator clocking needs further ten percent margin.
// - Inputs and driver enable ignore sub-20ns pulses; here only chip select (for execution) and driver enable are filtered.
// - Mode 3: idle high, change fall, sample rise.
// - Internal oscillator limits clock to 3.5 MHz.
// - All registers reset to zero.
// - Address plus 0x80 writes, plain address reads.
// - Writing one clears status bit, zero keeps.
// - Frame is address plus four bytes, MSB first.
// - Capture on rising edge, drive after falling.
// - Chip select rise executes shifted command.
// - Read happens once address bits arrived.
module spife_dev #(
  parameter int          NREG     = 4,
  parameter int          STAT_IDX = 1,
  parameter logic [3:0]  W1C_MASK = 4'h2
) (
  // System clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Serial link
  spife_if.dev             link,
  // Driver enable pin and status events
  input  wire logic        drv_en_low_i,
  input  wire logic [31:0] stat_set_i,
  // Command report, register view and filtered driver enable
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [6:0]       cmd_addr_o,
  output logic [31:0]      cmd_data_o,
  output logic [31:0]      ctrl_o,
  output logic [31:0]      stat_o,
  output logic             drv_en_low_filt_o
);

  localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic in_map(input logic [6:0] addr);
    in_map = (int'(addr) < NREG);
  endfunction : in_map

  // ---------------------------------------------------------------
  // Link clock domain
  // ---------------------------------------------------------------
  logic [5:0]  bit_cnt_ff;
  logic [5:0]  tx_idx_ff;
  logic [38:0] shift_ff;
  logic [39:0] cmd_ff;
  logic [7:0]  addr_ff;
  logic        full_ff;
  logic [31:0] rd_word_ff;
  logic [31:0] shadow_ff [NREG];
  logic [7:0]  last_addr_ff;
  logic        sdo;

  // Chip select high clears the bit count, so every frame starts at bit zero.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_ff <= 6'h00;
    end else if (bit_cnt_ff != spife_pkg::FRAME_FULL) begin
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
    end
  end

  // Longer frames keep the last forty bits, as a plain shift register would.
  always_ff @(posedge link.sck) begin
    shift_ff <= {shift_ff[37:0], link.sdi};
    full_ff  <= (bit_cnt_ff >= spife_pkg::FRAME_LAST);
    if (bit_cnt_ff == spife_pkg::ADDR_DONE - 6'h01) begin
      addr_ff <= {shift_ff[6:0], link.sdi};
    end
    if (bit_cnt_ff >= spife_pkg::FRAME_LAST) begin
      cmd_ff <= {shift_ff, link.sdi};
    end
  end

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      tx_idx_ff <= 6'h00;
    end else begin
      tx_idx_ff <= bit_cnt_ff;
    end
  end

  // The shadow bank is frozen while chip select is low, so this read sees a static word.
  always_ff @(negedge link.sck) begin
    if (bit_cnt_ff == spife_pkg::ADDR_DONE) begin
      rd_word_ff <= in_map(addr_ff[6:0]) ? shadow_ff[addr_ff[IW-1:0]] : spife_pkg::REG_RESET;
    end
  end

  always_comb begin
    if (tx_idx_ff < spife_pkg::ADDR_DONE) begin
      sdo = last_addr_ff[3'(3'h7 - tx_idx_ff[2:0])];
    end else if (tx_idx_ff < spife_pkg::FRAME_FULL) begin
      sdo = rd_word_ff[5'(spife_pkg::FRAME_LAST - tx_idx_ff)];
    end else begin
      sdo = 1'b0;
    end
  end

  assign link.sdo = sdo;

  // ---------------------------------------------------------------
  // Pin synchronisers and glitch filters
  // ---------------------------------------------------------------
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;
  logic [1:0] filt_ff;
  logic [1:0] fcnt_ff [2];
  logic       full_meta_ff;
  logic       full_sync_ff;
  logic       cs_filt_d_ff;
  logic       exec;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_ff      <= spife_pkg::PIN_IDLE;
      sync_ff      <= spife_pkg::PIN_IDLE;
      full_meta_ff <= 1'b0;
      full_sync_ff <= 1'b0;
    end else begin
      meta_ff      <= {drv_en_low_i, link.cs_n};
      sync_ff      <= meta_ff;
      full_meta_ff <= full_ff;
      full_sync_ff <= full_meta_ff;
    end
  end

  // A level must persist for the filter time before it is believed.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      filt_ff      <= spife_pkg::PIN_IDLE;
      cs_filt_d_ff <= 1'b1;
      for (int i = 0; i < 2; i++) begin
        fcnt_ff[i] <= 2'h0;
      end
    end else begin
      cs_filt_d_ff <= filt_ff[0];
      for (int i = 0; i < 2; i++) begin
        if (sync_ff[i] == filt_ff[i]) begin
          fcnt_ff[i] <= 2'h0;
        end else if (fcnt_ff[i] == 2'(spife_pkg::FILT_CYC - 1)) begin
          filt_ff[i] <= sync_ff[i];
          fcnt_ff[i] <= 2'h0;
        end else begin
          fcnt_ff[i] <= fcnt_ff[i] + 2'h1;
        end
      end
    end
  end

  // Frames of one to thirty-nine rises never execute; a frame with no rise reruns the last command unless such a frame came after it.
  // The link clock is idle when this samples cmd_ff.
  assign exec = filt_ff[0] & ~cs_filt_d_ff & full_sync_ff;

  // ---------------------------------------------------------------
  // Command execution and register bank
  // ---------------------------------------------------------------
  logic [31:0] regs_ff [NREG];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cmd_valid_o  <= 1'b0;
      cmd_write_o  <= 1'b0;
      cmd_addr_o   <= 7'h00;
      cmd_data_o   <= spife_pkg::REG_RESET;
      last_addr_ff <= spife_pkg::ADDR_RESET;
    end else begin
      cmd_valid_o <= exec;
      if (exec) begin
        cmd_write_o  <= cmd_ff[39];
        cmd_addr_o   <= cmd_ff[38:32];
        cmd_data_o   <= cmd_ff[31:0];
        last_addr_ff <= cmd_ff[39:32];
      end
    end
  end

  // Hardware set wins over a same-cycle software clear.
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < NREG; i++) begin
      if (srst_i) begin
        regs_ff[i] <= spife_pkg::REG_RESET;
      end else begin
        logic [31:0] nxt_reg;
        nxt_reg = regs_ff[i];
        if (exec && cmd_ff[39] && in_map(cmd_ff[38:32]) && (int'(cmd_ff[38:32]) == i)) begin
          nxt_reg = W1C_MASK[i] ? (regs_ff[i] & ~cmd_ff[31:0]) : cmd_ff[31:0];
        end
        if (i == STAT_IDX) begin
          nxt_reg = nxt_reg | stat_set_i;
        end
        regs_ff[i] <= nxt_reg;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < NREG; i++) begin
      if (srst_i) begin
        shadow_ff[i] <= spife_pkg::REG_RESET;
      end else if (sync_ff[0]) begin
        shadow_ff[i] <= regs_ff[i];
      end
    end
  end

  assign ctrl_o            = regs_ff[0];
  assign stat_o            = regs_ff[STAT_IDX];
  assign drv_en_low_filt_o = filt_ff[1];

endmodule : spife_dev

`default_nettype wire

// ==== hw/spife_host.sv ====
// Master end: divides its own clock to drive the serial link in mode 3.
`timescale 1ns/1ps
`default_nettype none

module spife_host #(
  parameter int HALF_CYC = spife_pkg::SCK_HALF_CYC,
  parameter int GAP_CYC  = spife_pkg::CS_GAP_CYC
) (
  // System clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Serial link
  spife_if.host            link,
  // Request
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [6:0]  req_addr_i,
  input  wire logic [31:0] req_data_i,
  output logic             req_ready_o,
  // Response
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_status_o,
  output logic [31:0]      rsp_data_o
);

  typedef enum logic [2:0] {
    SPIFE_IDLE  = 3'h0,
    SPIFE_LEAD  = 3'h1,
    SPIFE_SHIFT = 3'h3,
    SPIFE_TAIL  = 3'h2,
    SPIFE_GAP   = 3'h6
  } spife_hstate_t;

  spife_hstate_t state_ff;
  logic [15:0]   div_ff;
  logic          phase_ff;
  logic [5:0]    bit_ff;
  logic [39:0]   tx_ff;
  logic [39:0]   rx_ff;
  logic          sck_ff;
  logic          cs_n_ff;
  logic          sdi_ff;
  logic          sdo_meta_ff;
  logic          sdo_sync_ff;
  logic          tick;

  assign tick = (div_ff == 16'h0000);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sdo_meta_ff <= 1'b0;
      sdo_sync_ff <= 1'b0;
    end else begin
      sdo_meta_ff <= link.sdo;
      sdo_sync_ff <= sdo_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  // Each clock phase lasts HALF_CYC cycles, which keeps the rate under the slave limit.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_ff     <= SPIFE_IDLE;
      div_ff       <= 16'h0000;
      phase_ff     <= 1'b1;
      bit_ff       <= 6'h00;
      tx_ff        <= 40'h00_0000_0000;
      rx_ff        <= 40'h00_0000_0000;
      sck_ff       <= 1'b1;
      cs_n_ff      <= 1'b1;
      sdi_ff       <= 1'b0;
      rsp_valid_o  <= 1'b0;
      rsp_status_o <= spife_pkg::ADDR_RESET;
      rsp_data_o   <= spife_pkg::REG_RESET;
    end else begin
      rsp_valid_o <= 1'b0;
      if (!tick) begin
        div_ff <= div_ff - 16'h0001;
      end
      unique case (state_ff)
        SPIFE_IDLE: begin
          if (req_valid_i) begin
            tx_ff    <= {(req_write_i ? spife_pkg::WRITE_FLAG : spife_pkg::ADDR_RESET) | {1'b0, req_addr_i},
                         req_data_i};
            cs_n_ff  <= 1'b0;
            div_ff   <= 16'(HALF_CYC - 1);
            state_ff <= SPIFE_LEAD;
          end
        end
        SPIFE_LEAD: begin
          if (tick) begin
            sck_ff   <= 1'b0;
            sdi_ff   <= tx_ff[39];
            tx_ff    <= {tx_ff[38:0], 1'b0};
            phase_ff <= 1'b0;
            bit_ff   <= 6'h00;
            div_ff   <= 16'(HALF_CYC - 1);
            state_ff <= SPIFE_SHIFT;
          end
        end
        SPIFE_SHIFT: begin
          if (tick) begin
            div_ff <= 16'(HALF_CYC - 1);
            if (!phase_ff) begin
              sck_ff   <= 1'b1;
              phase_ff <= 1'b1;
            end else begin
              // Sampled late in the high phase so the two-stage sync still shows this bit.
              rx_ff <= {rx_ff[38:0], sdo_sync_ff};
              if (bit_ff == spife_pkg::FRAME_LAST) begin
                state_ff <= SPIFE_TAIL;
              end else begin
                sck_ff   <= 1'b0;
                sdi_ff   <= tx_ff[39];
                tx_ff    <= {tx_ff[38:0], 1'b0};
                phase_ff <= 1'b0;
                bit_ff   <= bit_ff + 6'h01;
              end
            end
          end
        end
        SPIFE_TAIL: begin
          if (tick) begin
            cs_n_ff      <= 1'b1;
            div_ff       <= 16'(GAP_CYC - 1);
            rsp_valid_o  <= 1'b1;
            rsp_status_o <= rx_ff[39:32];
            rsp_data_o   <= rx_ff[31:0];
            state_ff     <= SPIFE_GAP;
          end
        end
        SPIFE_GAP: begin
          if (tick) begin
            state_ff <= SPIFE_IDLE;
          end
        end
        default: begin
          state_ff <= SPIFE_IDLE;
        end
      endcase
    end
  end

  assign req_ready_o = (state_ff == SPIFE_IDLE);
  assign link.sck    = sck_ff;
  assign link.cs_n   = cs_n_ff;
  assign link.sdi    = sdi_ff;

endmodule : spife_host

`default_nettype wire

// ==== bench/spife_monitor.sv ====
// Link-level assertions watching the serial wires between both ends.
`timescale 1ns/1ps
`default_nettype none

module spife_monitor (
  // System clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo
);
  // ---------------------------------------------------------------
  // Helper logic and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  logic       sck_ff;
  logic [5:0] rise_cnt_ff;

  always_ff @(posedge sys_clk_i) begin
    sck_ff <= sck;
  end

  // Rises are counted in the system domain by sampling sck; the slave counts them on the link clock edges themselves.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || cs_n) begin
      rise_cnt_ff <= 6'h00;
    end else if (sck && !sck_ff) begin
      rise_cnt_ff <= rise_cnt_ff + 6'h01;
    end
  end

  property p_idle_high;  cs_n |-> sck; endproperty
  property p_cs_lead;    $fell(cs_n) |-> sck [*3]; endproperty
  property p_low_phase;  $fell(sck) |-> !sck [*3]; endproperty
  property p_sdi_hold;   !cs_n && sck && $past(sck) |-> $stable(sdi); endproperty
  property p_sdo_hold;   !cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(sdo); endproperty
  property p_frame_len;  $rose(cs_n) |-> rise_cnt_ff == spife_pkg::FRAME_FULL; endproperty
  property p_cs_gap;     $rose(cs_n) |-> cs_n [*6]; endproperty
  property p_cs_tail;    $rose(cs_n) |-> $past(sck, 3) && sck; endproperty

  a_idle_high: assert property (p_idle_high) else $error("clock low while deselected");
  a_cs_lead:   assert property (p_cs_lead) else $error("clock fell too soon after select");
  a_low_phase: assert property (p_low_phase) else $error("clock low phase too short");
  a_sdi_hold:  assert property (p_sdi_hold) else $error("data in moved while clock high");
  a_sdo_hold:  assert property (p_sdo_hold) else $error("data out moved while clock high");
  a_frame_len: assert property (p_frame_len) else $error("frame not forty clock rises");
  a_cs_gap:    assert property (p_cs_gap) else $error("deselect gap too short");
  a_cs_tail:   assert property (p_cs_tail) else $error("clock not high before deselect");

  c_frame: cover property ($rose(cs_n));
  c_shift: cover property ($fell(sck));
  c_sdo:   cover property (!cs_n && sdo);
endmodule : spife_monitor

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench joining the master end and the slave end over one link.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ---------------------------------------------------------------
  // Signals, instances and wire sniffers
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        drv_en_low = 1'b1;
  logic [31:0] stat_set = 32'h0;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [6:0]  req_addr = 7'h00;
  logic [31:0] req_data = 32'h0;
  logic        req_ready, rsp_valid, cmd_valid, cmd_write, filt;
  logic [7:0]  rsp_status;
  logic [31:0] rsp_data, cmd_data, ctrl, stat;
  logic [6:0]  cmd_addr;
  logic [39:0] sh_i, sh_o;
  logic [31:0] mdl [4];
  logic [7:0]  prev_ab;
  int          error_cnt = 0, check_count = 0;

  always #5 sys_clk = ~sys_clk;

  spife_if link_if ();
  spife_host #(.HALF_CYC(4), .GAP_CYC(8)) u_spife_host (.sys_clk_i(sys_clk), .srst_i(srst), .link(link_if),
    .req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr), .req_data_i(req_data),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_status_o(rsp_status), .rsp_data_o(rsp_data));
  spife_dev u_spife_dev (.sys_clk_i(sys_clk), .srst_i(srst), .link(link_if), .drv_en_low_i(drv_en_low),
    .stat_set_i(stat_set), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_addr_o(cmd_addr),
    .cmd_data_o(cmd_data), .ctrl_o(ctrl), .stat_o(stat), .drv_en_low_filt_o(filt));
  spife_monitor u_spife_monitor (.sys_clk_i(sys_clk), .srst_i(srst), .sck(link_if.sck),
    .cs_n(link_if.cs_n), .sdi(link_if.sdi), .sdo(link_if.sdo));

  always @(posedge link_if.sck) begin
    if (!link_if.cs_n) begin
      sh_i <= {sh_i[38:0], link_if.sdi};
      sh_o <= {sh_o[38:0], link_if.sdo};
    end
  end

  // ---------------------------------------------------------------
  // Expectations, checks and transfers
  // ---------------------------------------------------------------
  function automatic logic [7:0] addr_byte(input logic w, input logic [6:0] a);
    return w ? (spife_pkg::WRITE_FLAG | {1'b0, a}) : {1'b0, a};
  endfunction : addr_byte

  function automatic logic [31:0] nxt_reg(input logic [6:0] a, input logic [31:0] old, input logic [31:0] d);
    return (a == 7'h01) ? (old & ~d) : d;
  endfunction : nxt_reg

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Reads here see the values settled before this edge; drives land on it by non-blocking assignment.
  task automatic tick();
    @(posedge sys_clk);
  endtask : tick

  task automatic bound(input int i, input int n);
    if (i >= n) begin
      error_cnt++;
      final_report();
    end
  endtask : bound

  task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
    logic [31:0] rd;
    int          i;
    rd = (a < 7'h04) ? mdl[a[1:0]] : 32'h0;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++) tick();
    bound(i, 300);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_data  <= d;
    tick();
    req_valid <= 1'b0;
    for (i = 0; i < 1000 && rsp_valid !== 1'b1; i++) tick();
    bound(i, 1000);
    chk(40'(rsp_status), 40'(prev_ab));
    chk(40'(rsp_data), 40'(rd));
    chk(sh_i, {addr_byte(w, a), d});
    chk(sh_o, {prev_ab, rd});
    for (i = 0; i < 30 && cmd_valid !== 1'b1; i++) tick();
    bound(i, 30);
    if (w && a < 7'h04) mdl[a[1:0]] = nxt_reg(a, mdl[a[1:0]], d);
    chk({cmd_write, cmd_addr, cmd_data}, {w, a, d});
    chk(40'(ctrl), 40'(mdl[0]));
    chk(40'(stat), 40'(mdl[1]));
    prev_ab = addr_byte(w, a);
  endtask : xfer

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int          i;
    logic [31:0] s;
    void'($urandom(32'ha6410bdb));
    foreach (mdl[k]) mdl[k] = spife_pkg::REG_RESET;
    prev_ab = spife_pkg::ADDR_RESET;
    repeat (20) tick();
    srst <= 1'b0;
    repeat (6) tick();
    chk({ctrl, cmd_valid, filt}, {32'h0, 1'b0, 1'b1});
    for (i = 0; i < 4; i++) xfer(1'b0, 7'(i), $urandom);
    $display("test reset_values done");
    xfer(1'b1, 7'h00, 32'hffff_ffff);
    xfer(1'b1, 7'h05, $urandom);
    xfer(1'b0, 7'h05, 32'h0);
    $display("test unmapped done");
    s = $urandom;
    stat_set <= s;
    tick();
    stat_set <= 32'h0;
    repeat (8) tick();
    mdl[1] = mdl[1] | s;
    chk(40'(stat), 40'(mdl[1]));
    xfer(1'b1, 7'h01, 32'h0);
    xfer(1'b1, 7'h01, $urandom);
    xfer(1'b0, 7'h01, 32'h0);
    $display("test clear_on_one done");
    drv_en_low <= 1'b0;
    tick();
    drv_en_low <= 1'b1;
    for (i = 0; i < 8; i++) begin
      tick();
      chk(40'(filt), 40'h1);
    end
    drv_en_low <= 1'b0;
    for (i = 0; i < 12 && filt !== 1'b0; i++) tick();
    chk(40'(filt), 40'h0);
    drv_en_low <= 1'b1;
    $display("test enable_filter done");
    for (i = 0; i < 16; i++) xfer(1'($urandom), 7'($urandom % 6), $urandom);
    $display("test random_frames done");
    srst <= 1'b1;
    repeat (2) tick();
    srst <= 1'b0;
    repeat (6) tick();
    chk(40'(ctrl), 40'h0);
    chk(40'(stat), 40'h0);
    $display("test mid_reset done");
    final_report();
  end
endmodule : testbench

`default_nettype wire
